/* design/chan_switch_cfg.svh */
`ifndef CHAN_SWITCH_CFG_SVH
`define CHAN_SWITCH_CFG_SVH
// Fixed upper five address bits; value is arbitrary
`define ADDR_FIXED 5'h0E
`define CTRL_RESET 8'h00
`define SEL_LSB 0
`define IRQ_LSB 4
`define CH_COUNT 4
`define BYTE_BITS 4'h8
`endif

/* design/chan_switch_pkg.sv */
`include "chan_switch_cfg.svh"
package chan_switch_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WR, ST_READ, ST_ACK_RD, ST_SKIP}
    bus_state_type;
  typedef struct packed {
    logic scl;
    logic sda;
  } line_pair_type;
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } line_event_type;
endpackage

/* design/line_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for bus lines and edge detection on the settled copy
module line_sync
  import chan_switch_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire line_pair_type raw,
  output line_pair_type lines,
  output line_event_type events
);
  line_pair_type meta_r, meta_nxt;
  line_pair_type sync_r, sync_nxt;
  line_pair_type prev_r, prev_nxt;

  always_comb begin
    meta_nxt = raw;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
    if (!resetn) begin
      meta_nxt = 2'h3;
      sync_nxt = 2'h3;
      prev_nxt = 2'h3;
    end
  end

  always_ff @(posedge clock) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
    prev_r <= prev_nxt;
  end

  assign lines = sync_r;
  // =====================================
  // Line events
  always_comb begin
    events.scl_rise = sync_r.scl && !prev_r.scl;
    events.scl_fall = !sync_r.scl && prev_r.scl;
    events.start = prev_r.scl && sync_r.scl && prev_r.sda && !sync_r.sda;
    events.stop = prev_r.scl && sync_r.scl && !prev_r.sda && sync_r.sda;
  end
endmodule

/* design/irq_combine.sv */
`timescale 1ns/1ps
`include "chan_switch_cfg.svh"
// Synchronises the four interrupt inputs and combines them
module irq_combine
  import chan_switch_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [`CH_COUNT-1:0] irq_in_n,
  output logic [`CH_COUNT-1:0] irq_active,
  output logic irq_out_oe_n
);
  logic [`CH_COUNT-1:0] meta_r, meta_nxt;
  logic [`CH_COUNT-1:0] sync_r, sync_nxt;
  logic irq_oe_r, irq_oe_nxt;
  genvar g;

  generate
    for (g = 0; g < `CH_COUNT; g++) begin : g_ch
      always_comb begin
        meta_nxt[g] = resetn ? !irq_in_n[g] : 1'b0;
        sync_nxt[g] = resetn ? meta_r[g] : 1'b0;
      end
    end
  endgenerate

  always_comb begin
    // Independent of channel selection
    irq_oe_nxt = resetn ? !(|sync_r) : 1'b1;
  end

  always_ff @(posedge clock) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
    irq_oe_r <= irq_oe_nxt;
  end

  assign irq_active = sync_r;
  assign irq_out_oe_n = irq_oe_r;

  property p_irq_low;
    @(posedge clock) disable iff (!resetn)
      (|sync_r) |=> !irq_oe_r;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt output not pulled low");

  property p_irq_release;
    @(posedge clock) disable iff (!resetn)
      (sync_r == 4'h0) |=> irq_oe_r;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt output not released");
endmodule

/* design/chan_switch_ctrl.sv */
`timescale 1ns/1ps
`include "chan_switch_cfg.svh"
module chan_switch_ctrl
  import chan_switch_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic ADDR_PIN_LOW,
  input wire logic ADDR_PIN_HIGH,
  input wire logic [`CH_COUNT-1:0] IRQ_IN_N,
  output logic IRQ_OUT,
  output logic IRQ_OUT_OE_N,
  output logic [`CH_COUNT-1:0] CHANNEL_ENABLE
);
  line_pair_type lines;
  line_event_type ev;
  logic [`CH_COUNT-1:0] irq_active;

  bus_state_type state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [`CH_COUNT-1:0] sel_r, sel_nxt;
  logic [`CH_COUNT-1:0] active_r, active_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic sda_drive_r, sda_drive_nxt;
  logic [1:0] apin_meta_r, apin_meta_nxt;
  logic [1:0] apin_r, apin_nxt;
  logic [6:0] own_addr;
  logic [7:0] rx_byte;

  line_sync u_line_sync (
    .clock(CLOCK),
    .resetn(RESETN),
    .raw({SCL_IN, SDA_IN}),
    .lines(lines),
    .events(ev)
  );

  irq_combine u_irq (
    .clock(CLOCK),
    .resetn(RESETN),
    .irq_in_n(IRQ_IN_N),
    .irq_active(irq_active),
    .irq_out_oe_n(IRQ_OUT_OE_N)
  );

  // =====================================
  // Address pins (synchronised)
  always_comb begin
    apin_meta_nxt = RESETN ? {ADDR_PIN_HIGH, ADDR_PIN_LOW} : 2'h0;
    apin_nxt = RESETN ? apin_meta_r : 2'h0;
  end

  always_ff @(posedge CLOCK) begin
    apin_meta_r <= apin_meta_nxt;
    apin_r <= apin_nxt;
  end

  assign own_addr = {`ADDR_FIXED, apin_r};
  assign rx_byte = {shift_r[6:0], lines.sda};

  // =====================================
  // Bus state machine
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    sel_nxt = sel_r;
    active_nxt = active_r;
    tx_nxt = tx_r;
    sda_drive_nxt = sda_drive_r;
    if (ev.stop) begin
      // Switching only at STOP keeps downstream lines idle high when joined
      active_nxt = sel_r;
      state_nxt = ST_IDLE;
      sda_drive_nxt = 1'b0;
    end else if (ev.start) begin
      // Any SDA edge with SCL high is control, never data
      state_nxt = ST_ADDR;
      bit_cnt_nxt = 4'h0;
      sda_drive_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sda_drive_nxt = 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          if (ev.scl_rise) begin
            shift_nxt = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          if (ev.scl_fall && bit_cnt_r == `BYTE_BITS) begin
            bit_cnt_nxt = 4'h0;
            if (state_r == ST_ADDR) begin
              if (shift_r[7:1] == own_addr) begin
                state_nxt = ST_ACK_ADDR;
                sda_drive_nxt = 1'b1;
              end else begin
                state_nxt = ST_SKIP;
              end
            end else begin
              sel_nxt = shift_r[`SEL_LSB +: `CH_COUNT];
              state_nxt = ST_ACK_WR;
              sda_drive_nxt = 1'b1;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (ev.scl_fall) begin
            if (shift_r[0]) begin
              // Interrupt levels sampled at the moment the byte is loaded
              tx_nxt = {irq_active, sel_r};
              sda_drive_nxt = !irq_active[3];
              state_nxt = ST_READ;
            end else begin
              sda_drive_nxt = 1'b0;
              state_nxt = ST_WRITE;
            end
          end
        end
        ST_ACK_WR: begin
          if (ev.scl_fall) begin
            sda_drive_nxt = 1'b0;
            state_nxt = ST_WRITE;
          end
        end
        ST_READ: begin
          if (ev.scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          if (ev.scl_fall) begin
            if (bit_cnt_r == `BYTE_BITS) begin
              bit_cnt_nxt = 4'h0;
              sda_drive_nxt = 1'b0;
              state_nxt = ST_ACK_RD;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              sda_drive_nxt = !tx_r[6];
            end
          end
        end
        ST_ACK_RD: begin
          if (ev.scl_rise) begin
            shift_nxt = {7'h00, lines.sda};
          end
          if (ev.scl_fall) begin
            if (shift_r[0]) begin
              // No acknowledge: line stays released for the STOP
              sda_drive_nxt = 1'b0;
              state_nxt = ST_SKIP;
            end else begin
              tx_nxt = {irq_active, sel_r};
              sda_drive_nxt = !irq_active[3];
              state_nxt = ST_READ;
            end
          end
        end
        default: begin
          sda_drive_nxt = 1'b0;
        end
      endcase
    end
    if (!RESETN) begin
      // Same clear serves the reset pin and the power-on reset
      state_nxt = ST_IDLE;
      bit_cnt_nxt = 4'h0;
      shift_nxt = 8'h00;
      sel_nxt = 4'(`CTRL_RESET);
      active_nxt = 4'(`CTRL_RESET);
      tx_nxt = 8'h00;
      sda_drive_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    state_r <= state_nxt;
    bit_cnt_r <= bit_cnt_nxt;
    shift_r <= shift_nxt;
    sel_r <= sel_nxt;
    active_r <= active_nxt;
    tx_r <= tx_nxt;
    sda_drive_r <= sda_drive_nxt;
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = !sda_drive_r;
  assign IRQ_OUT = 1'b0;
  assign CHANNEL_ENABLE = active_r;

  // =====================================
  // Checks
  property p_switch_at_stop;
    @(posedge CLOCK) disable iff (!RESETN)
      !ev.stop |=> $stable(active_r);
  endproperty
  a_switch_at_stop: assert property (p_switch_at_stop) else $error("channels changed outside STOP");

  property p_stop_loads;
    @(posedge CLOCK) disable iff (!RESETN)
      ev.stop |=> active_r == $past(sel_r);
  endproperty
  a_stop_loads: assert property (p_stop_loads) else $error("STOP did not apply selection");

  property p_reset_clear;
    @(posedge CLOCK) !RESETN |=> (active_r == 4'h0 && sel_r == 4'h0 && state_r == ST_IDLE);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

  property p_write_store;
    @(posedge CLOCK) disable iff (!RESETN)
      (state_r == ST_WRITE && ev.scl_fall && bit_cnt_r == 4'h8 && !ev.stop && !ev.start)
      |=> sel_r == $past(shift_r[3:0]) && state_r == ST_ACK_WR;
  endproperty
  a_write_store: assert property (p_write_store) else $error("data byte not stored");

  property p_ack_hold;
    @(posedge CLOCK) disable iff (!RESETN)
      (state_r == ST_ACK_WR && lines.scl) |-> !SDA_OE_N;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge not held");

  property p_read_load;
    @(posedge CLOCK) disable iff (!RESETN)
      (state_r == ST_ACK_ADDR && ev.scl_fall && shift_r[0] && !ev.stop && !ev.start)
      |=> tx_r == {$past(irq_active), $past(sel_r)};
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte wrong");

  property p_nack_release;
    @(posedge CLOCK) disable iff (!RESETN)
      (state_r == ST_ACK_RD && ev.scl_fall && shift_r[0] && !ev.stop && !ev.start) |=> SDA_OE_N [*2];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("SDA not released after NACK");

  property p_idle_release;
    @(posedge CLOCK) disable iff (!RESETN)
      state_r == ST_IDLE |-> SDA_OE_N;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("SDA driven while idle");

  property p_addr_ack_hold;
    @(posedge CLOCK) disable iff (!RESETN)
      (state_r == ST_ACK_ADDR && lines.scl) |-> !SDA_OE_N;
  endproperty
  a_addr_ack_hold: assert property (p_addr_ack_hold) else $error("address acknowledge not held");

  // Foreign traffic belongs to other targets, so the line stays free
  property p_skip_quiet;
    @(posedge CLOCK) disable iff (!RESETN)
      state_r == ST_SKIP |-> SDA_OE_N;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("SDA driven while not addressed");

  property p_ack_rd_release;
    @(posedge CLOCK) disable iff (!RESETN)
      state_r == ST_ACK_RD |-> SDA_OE_N;
  endproperty
  a_ack_rd_release: assert property (p_ack_rd_release) else $error("SDA driven in controller acknowledge");

  property p_start_restart;
    @(posedge CLOCK) disable iff (!RESETN)
      (ev.start && !ev.stop) |=> (state_r == ST_ADDR && bit_cnt_r == 4'h0);
  endproperty
  a_start_restart: assert property (p_start_restart) else $error("START did not restart address phase");

  property p_bit_bound;
    @(posedge CLOCK) disable iff (!RESETN)
      bit_cnt_r <= `BYTE_BITS;
  endproperty
  a_bit_bound: assert property (p_bit_bound) else $error("bit counter beyond one byte");

  property p_sel_hold;
    @(posedge CLOCK) disable iff (!RESETN)
      !(state_r == ST_WRITE && ev.scl_fall && bit_cnt_r == `BYTE_BITS) |=> $stable(sel_r);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection changed outside data byte");

  c_write: cover property (@(posedge CLOCK) disable iff (!RESETN) state_r == ST_ACK_WR);
  c_read: cover property (@(posedge CLOCK) disable iff (!RESETN) state_r == ST_READ);
  c_switch: cover property (@(posedge CLOCK) disable iff (!RESETN) ev.stop && sel_r != active_r);
  c_read_again: cover property (@(posedge CLOCK) disable iff (!RESETN) state_r == ST_ACK_RD && ev.scl_fall && !shift_r[0]);
  c_skip_stop: cover property (@(posedge CLOCK) disable iff (!RESETN) state_r == ST_SKIP && ev.stop);
endmodule

/* bench/i2c_master_model.sv */
`timescale 1ns/1ps
// ==========
// Bus controller model, 160 ns bit made of 40 ns quarters
module i2c_master_model (
  output logic scl,
  output logic sda_o,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // ==========
  // Framing; clock stands high between frames
  task automatic bus_start();
    sda_o = 1'b1;
    #40 scl = 1'b1;
    #40 sda_o = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic bus_stop();
    sda_o = 1'b0;
    #40 scl = 1'b1;
    #40 sda_o = 1'b1;
    #40;
  endtask
  // Data only moves while the clock is low
  task automatic put_bit(input logic b, output logic got);
    sda_o = b;
    #40 scl = 1'b1;
    #40 got = sda;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i], b);
    put_bit(1'b1, b);
    ack = ~b;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(last, b);
  endtask
endmodule

/* bench/chan_switch_ctrl_tb.sv */
`timescale 1ns/1ps
`include "chan_switch_cfg.svh"
module chan_switch_ctrl_tb;
  typedef struct packed {
    logic [1:0] pins;
    logic [7:0] data;
    logic [3:0] irq_n;
    logic [3:0] exp_en;
    logic [7:0] exp_rd;
    logic exp_oe_n;
  } row_type;
  row_type rows [4] = '{
    '{2'h0, 8'hA1, 4'hF, 4'h1, 8'h01, 1'b1},
    '{2'h1, 8'h56, 4'hE, 4'h6, 8'h16, 1'b0},
    '{2'h2, 8'h0F, 4'h5, 4'hF, 8'hAF, 1'b0},
    '{2'h3, 8'hF0, 4'h0, 4'h0, 8'hF0, 1'b0}};
  logic clk, rst_n, a_lo, a_hi, sda_out, sda_oe_n, irq_out, irq_oe_n, scl, sda_m, ack;
  logic [3:0] irq_n, ch_en, cur_en;
  logic [7:0] rd;
  int num_errors = 0;
  int comparisons = 0;
  // Pull-up on the data line; either party may pull it low
  wire sda = (sda_oe_n ? 1'b1 : sda_out) & sda_m;
  chan_switch_ctrl chan_switch_ctrl_i (.CLOCK(clk), .RESETN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDR_PIN_LOW(a_lo), .ADDR_PIN_HIGH(a_hi),
    .IRQ_IN_N(irq_n), .IRQ_OUT(irq_out), .IRQ_OUT_OE_N(irq_oe_n), .CHANNEL_ENABLE(ch_en));
  i2c_master_model i2c_master_model_i (.scl(scl), .sda_o(sda_m), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // Helpers
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic do_write(input logic [1:0] pins, input logic [7:0] d);
    i2c_master_model_i.bus_start();
    i2c_master_model_i.wr_byte({`ADDR_FIXED, pins, 1'b0}, ack);
    check("addr_ack", 8'h01, {7'h00, ack});
    i2c_master_model_i.wr_byte(d, ack);
    check("data_ack", 8'h01, {7'h00, ack});
  endtask
  task automatic do_read(input logic [1:0] pins, output logic [7:0] d);
    i2c_master_model_i.bus_start();
    i2c_master_model_i.wr_byte({`ADDR_FIXED, pins, 1'b1}, ack);
    check("read_ack", 8'h01, {7'h00, ack});
    i2c_master_model_i.rd_byte(1'b1, d);
    i2c_master_model_i.bus_stop();
  endtask
  task automatic final_report();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  // ==========
  // Main sequence
  initial begin
    rst_n = 1'b0;
    a_lo = 1'b0;
    a_hi = 1'b0;
    irq_n = 4'hF;
    cur_en = 4'h0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check("enable_reset", 8'h00, {4'h0, ch_en});
    foreach (rows[k]) begin
      {a_hi, a_lo} = rows[k].pins;
      irq_n = rows[k].irq_n;
      repeat (8) @(negedge clk);
      do_write(rows[k].pins, rows[k].data);
      check("enable_before_stop", {4'h0, cur_en}, {4'h0, ch_en});
      i2c_master_model_i.bus_stop();
      repeat (8) @(negedge clk);
      check("enable", {4'h0, rows[k].exp_en}, {4'h0, ch_en});
      cur_en = rows[k].exp_en;
      do_read(rows[k].pins, rd);
      check("read_byte", rows[k].exp_rd, rd);
      check("irq_oe_n", {7'h00, rows[k].exp_oe_n}, {7'h00, irq_oe_n});
    end
    // Several bytes in one frame, last one wins
    irq_n = 4'hF;
    do_write(2'h3, 8'h03);
    i2c_master_model_i.wr_byte(8'h0C, ack);
    check("ack_second", 8'h01, {7'h00, ack});
    i2c_master_model_i.wr_byte(8'h09, ack);
    check("ack_third", 8'h01, {7'h00, ack});
    i2c_master_model_i.bus_stop();
    repeat (8) @(negedge clk);
    check("enable_last", 8'h09, {4'h0, ch_en});
    check("irq_released", 8'h01, {7'h00, irq_oe_n});
    // Foreign address must be ignored
    i2c_master_model_i.bus_start();
    i2c_master_model_i.wr_byte({`ADDR_FIXED, 2'h0, 1'b0}, ack);
    check("foreign_ack", 8'h00, {7'h00, ack});
    i2c_master_model_i.wr_byte(8'h0F, ack);
    i2c_master_model_i.bus_stop();
    repeat (8) @(negedge clk);
    check("enable_kept", 8'h09, {4'h0, ch_en});
    // Interrupt on an unselected channel; controller acknowledges once
    irq_n = 4'hB;
    repeat (8) @(negedge clk);
    check("irq_out", 8'h00, {7'h00, irq_out});
    check("irq_oe_n_unsel", 8'h00, {7'h00, irq_oe_n});
    i2c_master_model_i.bus_start();
    i2c_master_model_i.wr_byte({`ADDR_FIXED, 2'h3, 1'b1}, ack);
    check("read_ack_two", 8'h01, {7'h00, ack});
    i2c_master_model_i.rd_byte(1'b0, rd);
    check("read_first", 8'h49, rd);
    i2c_master_model_i.rd_byte(1'b1, rd);
    check("read_second", 8'h49, rd);
    i2c_master_model_i.bus_stop();
    irq_n = 4'hF;
    // Reset in mid-run drops every channel
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    check("enable_in_reset", 8'h00, {4'h0, ch_en});
    check("sda_in_reset", 8'h01, {7'h00, sda_oe_n});
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    do_read(2'h3, rd);
    check("read_after_reset", 8'h00, rd);
    final_report();
  end
endmodule
